// file: hw/frr_pkg.sv
// Package: register map, field layout, reset values and timing of the fault response block
package frr_pkg;
  localparam logic [7:0]  ADDR_UT_RESP      = 8'h54;
  localparam logic [7:0]  ADDR_VIN_OV_LIMIT = 8'h55;
  localparam logic [7:0]  ADDR_VIN_OV_RESP  = 8'h56;
  localparam logic [7:0]  RESP_RESET        = 8'h80;
  localparam logic [15:0] VIN_OV_LIMIT_RESET = 16'hD380;
  localparam int          MODE_HI = 7;
  localparam int          MODE_LO = 6;
  localparam int          RETRY_HI = 5;
  localparam int          RETRY_LO = 3;
  localparam logic [1:0]  MODE_DISABLE_RETRY = 2'h2;
  localparam logic [2:0]  RETRY_NONE    = 3'h0;
  localparam logic [2:0]  RETRY_FOREVER = 3'h7;
  localparam int          CLK_HZ        = 50000000;
  localparam int          UT_RETRY_MS   = 210;
  localparam int          OV_RETRY_MS   = 70;
  localparam int          UT_RETRY_CYC  = UT_RETRY_MS * (CLK_HZ / 1000);
  localparam int          OV_RETRY_CYC  = OV_RETRY_MS * (CLK_HZ / 1000);
  localparam int          TMR_W         = 24;
endpackage : frr_pkg

// file: hw/frr_retry_timer.sv
// Retry interval counter shared by the under-temperature and overvoltage channels
`timescale 1ns/1ps
module frr_retry_timer #(
  parameter int TMR_W = 24
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rst,
  // Control
  input  wire logic             start,
  input  wire logic             abort,
  input  wire logic [TMR_W-1:0] interval,
  // Status
  output logic                  busy,
  output logic                  done
);
  logic [TMR_W-1:0] count;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      count <= '0;
      busy  <= 1'b0;
      done  <= 1'b0;
    end else begin
      done <= 1'b0;
      if (abort) begin
        busy <= 1'b0;
      end else if (start) begin
        count <= interval;
        busy  <= 1'b1;
      end else if (busy) begin
        if (count <= 1) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          count <= count - 1'b1;
        end
      end
    end
  end
endmodule : frr_retry_timer

// file: hw/frr_fault_response.sv
// Under-temperature and input-overvoltage fault response registers and control
`timescale 1ns/1ps
module frr_fault_response
  import frr_pkg::*;
#(
  parameter int UT_RETRY_CYCLES = frr_pkg::UT_RETRY_CYC,
  parameter int OV_RETRY_CYCLES = frr_pkg::OV_RETRY_CYC
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // Register command port
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        write_protect,
  input  wire logic        clear_faults,
  output logic [15:0]      reg_rdata,
  output logic             reg_ack,
  // Fault sources
  input  wire logic        ut_sensor_fault_0,
  input  wire logic        ut_sensor_fault_1,
  input  wire logic        ut_sensor_en_0,
  input  wire logic        ut_sensor_en_1,
  input  wire logic [15:0] vin_meas,
  // Output control
  input  wire logic        control_on,
  input  wire logic        bias_ok,
  output logic             output_enable,
  output logic             alert_output_n,
  output logic             ut_fault_flag,
  output logic             vin_ov_fault_flag
);
  import frr_pkg::*;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_WAIT,
    ST_LATCHED
  } frr_state_e;

  logic [7:0]  undertemp_fault_response;
  logic [15:0] input_overvolt_fault_threshold;
  logic [7:0]  input_overvolt_fault_response;
  frr_state_e  state;
  logic        fault_src;
  logic        bias_meta, ov_meta;
  logic [15:0] vin_sync;
  logic [1:0]  ens_meta, ens_sync, ut_raw;
  logic        ut_cond, ov_cond, ut_retry, ov_retry;
  logic        tmr_start, tmr_busy, tmr_done, tmr_abort;
  logic [TMR_W-1:0] tmr_interval;
  logic [15:0] vin_stage;

  // Input synchronisers; first stage feeds only the second
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ut_raw    <= '0;
      bias_meta <= 1'b0;
      ens_meta  <= '0;
      ens_sync  <= '0;
      vin_stage <= '0;
      vin_sync  <= '0;
      ov_meta   <= 1'b0;
    end else begin
      ut_raw    <= {ut_sensor_fault_1, ut_sensor_fault_0};
      ens_meta  <= {ut_sensor_en_1, ut_sensor_en_0};
      ens_sync  <= ens_meta;
      vin_stage <= vin_meas;
      vin_sync  <= vin_stage;
      bias_meta <= bias_ok;
      ov_meta   <= bias_meta;
    end
  end

  logic [1:0] ut_meta2;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ut_meta2 <= '0;
    end else begin
      ut_meta2 <= ut_raw;
    end
  end

  // Linear-11 compare: same exponent assumed for reading and limit,
  // so mantissas compare as signed values
  assign ut_cond = |(ut_meta2 & ens_sync);
  assign ov_cond = $signed(vin_sync[10:0]) >
                   $signed(input_overvolt_fault_threshold[10:0]);

  assign ut_retry = (undertemp_fault_response[MODE_HI:MODE_LO] == MODE_DISABLE_RETRY) &&
                    (undertemp_fault_response[RETRY_HI:RETRY_LO] == RETRY_FOREVER);
  assign ov_retry = (input_overvolt_fault_response[MODE_HI:MODE_LO] == MODE_DISABLE_RETRY) &&
                    (input_overvolt_fault_response[RETRY_HI:RETRY_LO] == RETRY_FOREVER);

  // Register writes; protection blocks all writes
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      undertemp_fault_response       <= RESP_RESET;
      input_overvolt_fault_threshold <= VIN_OV_LIMIT_RESET;
      input_overvolt_fault_response  <= RESP_RESET;
    end else if (reg_wr && !write_protect) begin
      case (reg_addr)
        ADDR_UT_RESP:      undertemp_fault_response       <= reg_wdata[7:0];
        ADDR_VIN_OV_LIMIT: input_overvolt_fault_threshold <= reg_wdata;
        ADDR_VIN_OV_RESP:  input_overvolt_fault_response  <= reg_wdata[7:0];
        default: ;
      endcase
    end
  end

  // Read path, one cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      reg_rdata <= '0;
      reg_ack   <= 1'b0;
    end else begin
      reg_ack <= reg_rd | reg_wr;
      if (reg_rd) begin
        case (reg_addr)
          ADDR_UT_RESP:      reg_rdata <= {8'h00, undertemp_fault_response};
          ADDR_VIN_OV_LIMIT: reg_rdata <= input_overvolt_fault_threshold;
          ADDR_VIN_OV_RESP:  reg_rdata <= {8'h00, input_overvolt_fault_response};
          default:           reg_rdata <= 16'h0000;
        endcase
      end
    end
  end

  // Sticky flags; a new fault wins over a clear in the same cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ut_fault_flag     <= 1'b0;
      vin_ov_fault_flag <= 1'b0;
      alert_output_n    <= 1'b1;
    end else begin
      ut_fault_flag     <= ut_cond | (ut_fault_flag & ~clear_faults);
      vin_ov_fault_flag <= ov_cond | (vin_ov_fault_flag & ~clear_faults);
      alert_output_n    <= ~(ut_cond | ov_cond |
                            ((ut_fault_flag | vin_ov_fault_flag) & ~clear_faults));
    end
  end

  // Retry sequencing; off command, bias loss or other fault ends waiting
  always_comb begin
    tmr_start    = 1'b0;
    tmr_interval = TMR_W'(UT_RETRY_CYCLES);
    if (state == ST_RUN && (ut_cond || ov_cond)) begin
      tmr_start    = ut_cond ? ut_retry : ov_retry;
      tmr_interval = ut_cond ? TMR_W'(UT_RETRY_CYCLES) : TMR_W'(OV_RETRY_CYCLES);
    end
  end
  assign tmr_abort = !control_on || !ov_meta;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state         <= ST_RUN;
      fault_src     <= 1'b0;
      output_enable <= 1'b0;
    end else begin
      case (state)
        ST_RUN: begin
          output_enable <= control_on & ov_meta & ~ut_cond & ~ov_cond;
          if (ut_cond || ov_cond) begin
            fault_src <= ut_cond;
            state     <= tmr_start ? ST_WAIT : ST_LATCHED;
          end
        end
        ST_WAIT: begin
          output_enable <= 1'b0;
          if (tmr_abort || (fault_src ? ov_cond : ut_cond)) begin
            state <= ST_LATCHED;
          end else if (tmr_done) begin
            state <= ST_RUN;
          end
        end
        ST_LATCHED: begin
          output_enable <= 1'b0;
          // Overvoltage releases on clear-faults; under-temperature only on reset
          if (!fault_src && clear_faults && !ov_cond) begin
            state <= ST_RUN;
          end
        end
        default: state <= ST_RUN;
      endcase
    end
  end

  frr_retry_timer #(
    .TMR_W (TMR_W)
  ) u_timer (
    .mclk     (mclk),
    .rst      (rst),
    .start    (tmr_start),
    .abort    (tmr_abort),
    .interval (tmr_interval),
    .busy     (tmr_busy),
    .done     (tmr_done)
  );
endmodule : frr_fault_response

// file: bench/frr_props.sv
// Checker for the fault response block ports
`timescale 1ns/1ps
module frr_props (
  // Clock, reset and command port
  input wire logic        mclk, rst, reg_wr, reg_rd, reg_ack, clear_faults,
  input wire logic [7:0]  reg_addr,
  input wire logic [15:0] reg_rdata,
  // Fault and output state
  input wire logic        control_on, output_enable, alert_output_n,
  input wire logic        ut_fault_flag, vin_ov_fault_flag
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  chk_ack_after_req: assert property ((reg_wr || reg_rd) |=> reg_ack)
    else $error("ack missing");
  chk_ack_no_req: assert property (!(reg_wr || reg_rd) |=> !reg_ack)
    else $error("stray ack");
  chk_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved");
  chk_unmapped_zero: assert property (reg_rd && !(reg_addr inside {8'h54, 8'h55, 8'h56})
    |=> reg_rdata == 16'h0000) else $error("unmapped read not zero");
  chk_alert_on_flag: assert property ((ut_fault_flag || vin_ov_fault_flag) |-> !alert_output_n)
    else $error("alert not low");
  chk_ut_sticky: assert property (ut_fault_flag && !clear_faults |=> ut_fault_flag)
    else $error("ut flag dropped");
  chk_ov_sticky: assert property (vin_ov_fault_flag && !clear_faults |=> vin_ov_fault_flag)
    else $error("ov flag dropped");
  chk_fault_stops: assert property ($rose(ut_fault_flag) || $rose(vin_ov_fault_flag)
    |-> ##[0:2] !output_enable) else $error("output kept on");
  chk_off_command: assert property ($fell(control_on) |-> ##[0:3] !output_enable)
    else $error("output ignores off");
endmodule : frr_props
bind frr_fault_response frr_props u_props (.*);

// file: bench/frr_host.sv
// Host model for the register command port
`timescale 1ns/1ps
module frr_host (
  // Answer from the device
  input wire logic        mclk, reg_ack,
  input wire logic [15:0] reg_rdata,
  // Requests
  output logic            reg_wr, reg_rd,
  output logic [7:0]      reg_addr,
  output logic [15:0]     reg_wdata
);
  initial begin
    {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
  end
  // Request held until ack is seen or four clocks pass; released address and data show the inverse so stale values never pass
  task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d,
                      output logic [15:0] q, output bit ok);
    int i;
    ok = 0;
    q  = 'x;
    @(posedge mclk);
    reg_wr <= w; reg_rd <= !w; reg_addr <= a; reg_wdata <= d;
    for (i = 0; i < 4 && !ok; i++) begin
      @(posedge mclk);
      if (reg_ack === 1'b1) begin
        ok = 1; q = reg_rdata;
      end
    end
    reg_wr <= 1'b0; reg_rd <= 1'b0; reg_addr <= ~a; reg_wdata <= ~d;
  endtask : xfer
endmodule : frr_host

// file: bench/tb.sv
// Testbench for the fault response block
`timescale 1ns/1ps
module tb;
  import frr_pkg::*;
  localparam int UTC = 40, OVC = 20;
  logic        mclk, rst, write_protect, clear_faults, ut_sensor_fault_0, ut_sensor_fault_1;
  logic        ut_sensor_en_0, ut_sensor_en_1, control_on, bias_ok, reg_wr, reg_rd, reg_ack;
  logic        output_enable, alert_output_n, ut_fault_flag, vin_ov_fault_flag;
  logic [7:0]  reg_addr;
  logic [15:0] vin_meas, reg_rdata, reg_wdata, lfsr, q;
  logic [15:0] ex [3];
  int          fail_count = 0, n_tests = 0, i, k, gap;
  frr_fault_response #(.UT_RETRY_CYCLES(UTC), .OV_RETRY_CYCLES(OVC)) u_dut (.*);
  frr_host u_host (.*);
  initial begin
    mclk = 0;
    forever #10 mclk = ~mclk;
  end
  function automatic logic [15:0] step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : step
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d);
    bit ok;
    u_host.xfer(w, a, d, q, ok);
    if (!ok) begin
      fail_count++;
      stop_test();
    end
  endtask : acc
  // Cycles until output enable reaches v, sampled mid-cycle
  task automatic wait_oe(input logic v, input int lim);
    for (gap = 0; gap < lim && output_enable !== v; gap++) @(negedge mclk);
    if (gap == lim) begin
      fail_count++;
      stop_test();
    end
  endtask : wait_oe
  task automatic pulse_clear();
    @(posedge mclk) clear_faults <= 1'b1;
    @(posedge mclk) clear_faults <= 1'b0;
  endtask : pulse_clear
  task automatic do_reset();
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
  endtask : do_reset
  initial begin
    {rst, write_protect, clear_faults, ut_sensor_fault_0, ut_sensor_fault_1} = 5'h10;
    {ut_sensor_en_0, ut_sensor_en_1, control_on, bias_ok} = 4'hB;
    vin_meas = 16'hD400; // Most negative mantissa: random limits never trip
    lfsr = 16'h3946;
    ex = '{16'h0080, 16'hD380, 16'h0080};
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    for (k = 0; k < 3; k++) begin
      acc(0, ADDR_UT_RESP + 8'(k), 16'h0000);
      check("reset value", q, ex[k]);
    end
    acc(1, 8'h57, 16'hFFFF);
    acc(0, 8'h57, 16'h0000);
    check("unmapped", q, 16'h0000);
    for (i = 0; i < 15; i++) begin
      lfsr = step(lfsr);
      k = i % 3;
      write_protect <= lfsr[0];
      acc(1, ADDR_UT_RESP + 8'(k), lfsr);
      if (!lfsr[0]) ex[k] = (k == 1) ? lfsr : {8'h00, lfsr[7:0]};
      write_protect <= 1'b0;
      acc(0, ADDR_UT_RESP + 8'(k), 16'h0000);
      check("readback", q, ex[k]);
    end
    $display("test registers done");
    do_reset();
    vin_meas <= 16'hD370;
    wait_oe(1, 10);
    ut_sensor_fault_1 <= 1'b1;
    repeat (8) @(negedge mclk);
    check("masked sensor", ut_fault_flag, 1'b0);
    ut_sensor_fault_1 <= 1'b0;
    ut_sensor_fault_0 <= 1'b1;
    wait_oe(0, 10);
    check("ut flag", ut_fault_flag, 1'b1);
    check("alert", alert_output_n, 1'b0);
    ut_sensor_fault_0 <= 1'b0;
    repeat (4) @(negedge mclk);
    pulse_clear();
    repeat (2 * UTC) @(negedge mclk);
    check("ut flag clear", ut_fault_flag, 1'b0);
    check("ut latched", output_enable, 1'b0);
    $display("test ut latched done");
    do_reset();
    acc(1, ADDR_UT_RESP, 16'h00B8);
    wait_oe(1, 10);
    ut_sensor_fault_0 <= 1'b1;
    wait_oe(0, 10);
    ut_sensor_fault_0 <= 1'b0;
    wait_oe(1, UTC + 20);
    check("ut gap", 16'(gap >= UTC && gap <= UTC + 6), 16'h0001);
    control_on <= 1'b0;
    wait_oe(0, 5);
    $display("test ut retry done");
    do_reset();
    control_on <= 1'b1;
    acc(1, ADDR_VIN_OV_RESP, 16'h00B8);
    wait_oe(1, 10);
    vin_meas <= 16'hD390;
    wait_oe(0, 10);
    vin_meas <= 16'hD370;
    wait_oe(1, OVC + 20);
    check("ov gap", 16'(gap >= OVC && gap <= OVC + 6), 16'h0001);
    check("ov flag", vin_ov_fault_flag, 1'b1);
    acc(1, ADDR_VIN_OV_RESP, 16'h0080);
    vin_meas <= 16'hD390;
    wait_oe(0, 10);
    vin_meas <= 16'hD370;
    repeat (2 * OVC) @(negedge mclk);
    check("ov latched", output_enable, 1'b0);
    pulse_clear();
    wait_oe(1, 10);
    check("ov flag clear", vin_ov_fault_flag, 1'b0);
    $display("test ov done");
    stop_test();
  end
endmodule : tb
